// >>> src/pfrs_sequencer.sv
// Supply supervision, reset sequencing and engine event routing
// Functional notes
// - Below upper threshold report 001, nothing else
// - Below lower threshold switch to battery
// - Status 000 on good power, 010 battery
// - Status 011 blocks every flash write
// - Status 101 resets chip after four crystal cycles
// - Status is read-only, bits 2:0 at f9
// - Every status change raises processor interrupt
// - Above lower threshold return to system power
// - Below lower threshold stop converter clocks, unbias
// - Reset pin high halts logic, clears controls
// - Test mux reset only with test pin
// - Software reset bit acts like pin, shorter
// - Timer expires after 4100 engine cycles, boot zero
// - Debug reset clears processor only, no timer
// - Transfer-done pulse ends each accumulation interval
// - Transfer-done routable to the test mux pin
// - Engine-busy and transfer-done interrupts; sag via pulse
// - Sleep with power present sleeps, then wakes
`timescale 1ns/1ps
`include "pfrs_defs.svh"
module pfrs_sequencer #(
  parameter int PIN_TIMER_CYCLES = `PFRS_PIN_TIMER_CYCLES,
  parameter int SW_TIMER_CYCLES  = `PFRS_SW_TIMER_CYCLES,
  parameter int COLLAPSE_CYCLES  = `PFRS_COLLAPSE_CYCLES,
  parameter int TIMER_W          = 13,
  parameter int SAMPLE_W         = 16
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic                upper_supply_ok,
  input  wire logic                lower_supply_ok,
  input  wire logic                core_above_225,
  input  wire logic                core_above_200,
  input  wire logic                crystal_clock_32k,
  input  wire logic                engine_clock_32k,
  input  wire logic                reset_pin,
  input  wire logic                test_pin,
  input  wire logic                debug_reset_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_rd,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata,
  input  wire logic [15:0]         io_addr,
  input  wire logic                io_rd,
  input  wire logic                io_wr,
  input  wire logic [7:0]          io_wdata,
  output logic      [7:0]          io_rdata,
  input  wire logic                flash_write_req,
  output logic                     flash_write_grant,
  input  wire logic                sample_strobe,
  input  wire logic [SAMPLE_W-1:0] accumulation_sample_count,
  input  wire logic                pulse_y_irq,
  output logic                     supply_irq,
  output logic                     transfer_done_irq,
  output logic                     engine_busy_irq,
  output logic                     test_mux_output,
  output logic                     battery_select,
  output logic                     converter_clock_enable,
  output logic                     amp_bias_enable,
  output logic                     flash_write_inhibit,
  output logic                     digital_halt,
  output logic                     chip_reset,
  output logic                     cpu_reset_n,
  output logic                     cpu_start,
  output logic      [15:0]         boot_addr,
  output logic                     wake
);

  localparam logic [TIMER_W-1:0] PIN_LOAD = TIMER_W'(PIN_TIMER_CYCLES);
  localparam logic [TIMER_W-1:0] SW_LOAD  = TIMER_W'(SW_TIMER_CYCLES);
  localparam logic [2:0]         COLLAPSE = 3'(COLLAPSE_CYCLES);

  // ==========================================================
  // Pin synchronisation
  logic [8:0] pins_s;
  logic       upper_s;
  logic       lower_s;
  logic       core225_s;
  logic       core200_s;
  logic       xtal_s;
  logic       eng_s;
  logic       rst_pin_s;
  logic       test_s;
  logic       dbg_n_s;

  // Comparators and debug reset idle high: a cleared stage would fake a collapse
  pfrs_sync #(
    .WIDTH     (9),
    .RESET_VAL (9'h1e1)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       ({upper_supply_ok, lower_supply_ok, core_above_225, core_above_200,
                crystal_clock_32k, engine_clock_32k, reset_pin, test_pin, debug_reset_n}),
    .q       (pins_s)
  );

  assign {upper_s, lower_s, core225_s, core200_s, xtal_s, eng_s, rst_pin_s, test_s, dbg_n_s} = pins_s;

  // ==========================================================
  // Slow clock edges
  logic xtal_q;
  logic eng_q;
  logic xtal_rise;
  logic eng_rise;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xtal_q <= 1'b0;
      eng_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      xtal_q <= xtal_s;
      eng_q  <= eng_s;
    end
  end

  assign xtal_rise = xtal_s & ~xtal_q;
  assign eng_rise  = eng_s & ~eng_q;

  // ==========================================================
  // Supply status
  pfrs_pkg::pfrs_status_t status;
  pfrs_pkg::pfrs_status_t next_status;

  always_comb
  begin
    if (upper_s)
      next_status = `PFRS_STATUS_OK;
    else if (lower_s)
      next_status = `PFRS_STATUS_LOW;
    else if (core225_s)
      next_status = `PFRS_STATUS_BATT_OK;
    else if (core200_s)
      next_status = `PFRS_STATUS_NO_FLASH;
    else
      next_status = `PFRS_STATUS_COLLAPSE;
  end

  // Status and its change flag share one edge, so no change is missed or doubled
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status     <= `PFRS_STATUS_OK;
      supply_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      status     <= next_status;
      supply_irq <= (next_status != status);
    end
  end

  // ==========================================================
  // Power path and converter control
  logic conv_en;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      battery_select         <= 1'b0;
      converter_clock_enable <= 1'b0;
      amp_bias_enable        <= 1'b0;
      flash_write_inhibit    <= 1'b0;
    end
    else if (clk_en)
    begin
      battery_select         <= ~lower_s;
      converter_clock_enable <= conv_en & lower_s;
      amp_bias_enable        <= lower_s;
      flash_write_inhibit    <= (next_status == `PFRS_STATUS_NO_FLASH) ||
                                (next_status == `PFRS_STATUS_COLLAPSE);
    end
  end

  assign flash_write_grant = flash_write_req & ~flash_write_inhibit;

  // ==========================================================
  // Core collapse timer
  logic [2:0] collapse_cnt;
  logic       collapse_hit;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      collapse_cnt <= 3'h0;
    else if (clk_en)
    begin
      if (status != `PFRS_STATUS_COLLAPSE)
        collapse_cnt <= 3'h0;
      else if (xtal_rise && !collapse_hit)
        collapse_cnt <= collapse_cnt + 3'h1;
    end
  end

  assign collapse_hit = (collapse_cnt == COLLAPSE);

  // ==========================================================
  // Reset sequencer
  pfrs_pkg::pfrs_state_t state;
  pfrs_pkg::pfrs_state_t next_state;
  logic [TIMER_W-1:0]    timer;
  logic                  hold_req;
  logic                  sw_reset;
  logic                  sleep_bit;
  logic                  load_pin;
  logic                  load_sw;
  logic                  ctrl_clear;

  // Pin and core collapse both hold the chip until they let go
  assign hold_req = rst_pin_s | collapse_hit;

  always_comb
  begin
    next_state = state;
    load_pin   = 1'b0;
    load_sw    = 1'b0;
    case (state)
      pfrs_pkg::st_hold:
        if (!hold_req)
        begin
          next_state = pfrs_pkg::st_timer;
          load_pin   = 1'b1;
        end
      pfrs_pkg::st_timer:
        if (hold_req)
          next_state = pfrs_pkg::st_hold;
        else if (timer == '0)
          next_state = pfrs_pkg::st_run;
      pfrs_pkg::st_run:
        if (hold_req)
          next_state = pfrs_pkg::st_hold;
        else if (sw_reset)
        begin
          next_state = pfrs_pkg::st_timer;
          load_sw    = 1'b1;
        end
        else if (sleep_bit)
          next_state = pfrs_pkg::st_sleep;
      pfrs_pkg::st_sleep:
        if (hold_req)
          next_state = pfrs_pkg::st_hold;
        else if (lower_s)
        begin
          next_state = pfrs_pkg::st_timer;
          load_pin   = 1'b1;
        end
      default:
        next_state = pfrs_pkg::st_hold;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= pfrs_pkg::st_hold;
    else if (clk_en)
      state <= next_state;
  end

  // Timer runs on engine clock edges, not on the fast clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timer <= PIN_LOAD;
    else if (clk_en)
    begin
      if (load_pin)
        timer <= PIN_LOAD;
      else if (load_sw)
        timer <= SW_LOAD;
      else if (state == pfrs_pkg::st_hold)
        timer <= PIN_LOAD;
      else if (state == pfrs_pkg::st_timer && eng_rise && timer != '0)
        timer <= timer - {{(TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chip_reset   <= 1'b1;
      cpu_reset_n  <= 1'b0;
      cpu_start    <= 1'b0;
      boot_addr    <= `PFRS_BOOT_ADDR;
      digital_halt <= 1'b1;
      wake         <= 1'b0;
    end
    else if (clk_en)
    begin
      chip_reset   <= (next_state == pfrs_pkg::st_hold) || (next_state == pfrs_pkg::st_timer);
      // Debug reset reaches only the processor and never starts the timer
      cpu_reset_n  <= dbg_n_s && (next_state == pfrs_pkg::st_run);
      cpu_start    <= (state == pfrs_pkg::st_timer) && (next_state == pfrs_pkg::st_run);
      boot_addr    <= `PFRS_BOOT_ADDR;
      digital_halt <= rst_pin_s;
      wake         <= (next_state != pfrs_pkg::st_sleep);
    end
  end

  // ==========================================================
  // Control bits
  logic [4:0] test_mux_select;
  logic       io_reset_hit;
  logic       io_sleep_hit;
  logic       io_conv_hit;
  logic       io_test_mux_select_hit;

  assign io_reset_hit = (io_addr == `PFRS_IO_RESET_CTRL);
  assign io_sleep_hit = (io_addr == `PFRS_IO_SLEEP_CTRL);
  assign io_conv_hit  = (io_addr == `PFRS_IO_CONV_CTRL);
  assign io_test_mux_select_hit  = (io_addr == `PFRS_IO_TEST_MUX);
  // Software reset clears the controls like the pin; waking from sleep drops the sleep bit
  assign ctrl_clear   = hold_req || (state == pfrs_pkg::st_hold) || load_sw ||
                        (state == pfrs_pkg::st_sleep && load_pin);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sw_reset  <= 1'b0;
      sleep_bit <= 1'b0;
      conv_en   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ctrl_clear)
      begin
        sw_reset  <= 1'b0;
        sleep_bit <= 1'b0;
        conv_en   <= 1'b0;
      end
      else if (io_wr)
      begin
        if (io_reset_hit)
          sw_reset <= io_wdata[`PFRS_SW_RESET_BIT];
        if (io_sleep_hit)
          sleep_bit <= io_wdata[`PFRS_SLEEP_BIT];
        if (io_conv_hit)
          conv_en <= io_wdata[`PFRS_CONV_EN_BIT];
      end
    end
  end

  // Test mux survives an ordinary reset so a scope keeps its trigger
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      test_mux_select <= `PFRS_TEST_MUX_RESET;
    else if (clk_en)
    begin
      if (rst_pin_s && test_s)
        test_mux_select <= `PFRS_TEST_MUX_RESET;
      else if (io_wr && io_test_mux_select_hit && !digital_halt)
        test_mux_select <= io_wdata[`PFRS_TEST_MUX_MSB:0];
    end
  end

  // ==========================================================
  // Register reads
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= 8'h00;
      io_rdata  <= 8'h00;
    end
    else if (clk_en)
    begin
      // Writes to the status address are dropped
      if (sfr_rd && sfr_addr == `PFRS_SFR_SUPPLY_STATUS)
        sfr_rdata <= {5'h00, status};
      else
        sfr_rdata <= 8'h00;
      io_rdata <= 8'h00;
      if (io_rd)
      begin
        if (io_reset_hit)
          io_rdata[`PFRS_SW_RESET_BIT] <= sw_reset;
        if (io_sleep_hit)
          io_rdata[`PFRS_SLEEP_BIT] <= sleep_bit;
        if (io_conv_hit)
          io_rdata[`PFRS_CONV_EN_BIT] <= conv_en;
        if (io_test_mux_select_hit)
          io_rdata[`PFRS_TEST_MUX_MSB:0] <= test_mux_select;
      end
    end
  end

  // ==========================================================
  // Compute engine events
  logic accum_busy;
  logic accum_done;

  pfrs_accum #(
    .CNT_W (SAMPLE_W)
  ) u_accum (
    .clk           (clk),
    .reset_n       (reset_n),
    .clk_en        (clk_en),
    .clear         (chip_reset),
    .sample_strobe (sample_strobe),
    .sample_count  (accumulation_sample_count),
    .busy          (accum_busy),
    .done          (accum_done)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      transfer_done_irq <= 1'b0;
      engine_busy_irq   <= 1'b0;
      test_mux_output   <= 1'b0;
    end
    else if (clk_en)
    begin
      transfer_done_irq <= accum_done;
      engine_busy_irq   <= accum_busy;
      case (test_mux_select)
        `PFRS_TEST_MUX_XFER: test_mux_output <= accum_done;
        `PFRS_TEST_MUX_SAG:  test_mux_output <= pulse_y_irq;
        default:             test_mux_output <= 1'b0;
      endcase
    end
  end

  // sfr_wdata and sfr_wr reach no storage: the status field ignores writes
  logic unused_sfr;
  assign unused_sfr = sfr_wr ^ (^sfr_wdata);

endmodule

// >>> src/pfrs_defs.svh
// Offsets, field positions, reset values and timing counts of the supply and reset sequencer
`ifndef PFRS_DEFS_SVH
`define PFRS_DEFS_SVH

// ==========================================================
// Register map
`define PFRS_SFR_SUPPLY_STATUS 8'hf9
`define PFRS_IO_RESET_CTRL     16'h2200
`define PFRS_IO_SLEEP_CTRL     16'h28b2
`define PFRS_IO_CONV_CTRL      16'h2704
`define PFRS_IO_TEST_MUX       16'h2502

// ==========================================================
// Field positions
`define PFRS_SW_RESET_BIT      3
`define PFRS_SLEEP_BIT         7
`define PFRS_CONV_EN_BIT       4
`define PFRS_TEST_MUX_MSB      4

// ==========================================================
// Supply status codes
`define PFRS_STATUS_OK         3'h0
`define PFRS_STATUS_LOW        3'h1
`define PFRS_STATUS_BATT_OK    3'h2
`define PFRS_STATUS_NO_FLASH   3'h3
`define PFRS_STATUS_COLLAPSE   3'h5

// ==========================================================
// Reset values and test mux codes
`define PFRS_TEST_MUX_RESET    5'h00
`define PFRS_TEST_MUX_XFER     5'h18
`define PFRS_TEST_MUX_SAG      5'h19
`define PFRS_BOOT_ADDR         16'h0000

// ==========================================================
// Timing counts
`define PFRS_PIN_TIMER_CYCLES  4100
`define PFRS_SW_TIMER_CYCLES   16
`define PFRS_COLLAPSE_CYCLES   4

`endif

// >>> src/pfrs_pkg.sv
// Types shared by the supply and reset sequencer
package pfrs_pkg;

  // ==========================================================
  // Sequencer states, Gray along hold, timer, run
  typedef enum logic [1:0]
  {
    st_hold  = 2'b00,
    st_timer = 2'b01,
    st_run   = 2'b11,
    st_sleep = 2'b10
  } pfrs_state_t;

  typedef logic [2:0] pfrs_status_t;

endpackage

// >>> src/pfrs_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pfrs_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ==========================================================
  // Stages
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Stages clear to each pin's idle level, so release shows no false event
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// >>> src/pfrs_accum.sv
// Accumulation interval counter of the compute engine
`timescale 1ns/1ps
module pfrs_accum #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             clear,
  input  wire logic             sample_strobe,
  input  wire logic [CNT_W-1:0] sample_count,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             last;

  assign next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
  // A zero count behaves as one sample per interval
  assign last       = (next_count >= sample_count);

  // ==========================================================
  // Sample counting
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      done  <= 1'b0;
      busy  <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (clear)
      begin
        count <= '0;
        busy  <= 1'b0;
      end
      else if (sample_strobe)
      begin
        if (last)
        begin
          count <= '0;
          done  <= 1'b1;
          busy  <= 1'b0;
        end
        else
        begin
          count <= next_count;
          busy  <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> tb/pfrs_props.sv
// Port-level checks of the supply and reset sequencer
`timescale 1ns/1ps
module pfrs_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        flash_write_req,
  input wire logic        flash_write_grant,
  input wire logic        flash_write_inhibit,
  input wire logic        battery_select,
  input wire logic        amp_bias_enable,
  input wire logic        converter_clock_enable,
  input wire logic        supply_irq,
  input wire logic        transfer_done_irq,
  input wire logic        digital_halt,
  input wire logic        chip_reset,
  input wire logic        cpu_reset_n,
  input wire logic        debug_reset_n,
  input wire logic        cpu_start,
  input wire logic [15:0] boot_addr
);
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_grant_gated: assert property (flash_write_grant == (flash_write_req && !flash_write_inhibit))
    else $error("flash grant wrong");
  a_batt_unbias: assert property (battery_select |-> !amp_bias_enable && !converter_clock_enable)
    else $error("bias or converter clock on battery");
  a_batt_return: assert property ($fell(battery_select) |-> amp_bias_enable)
    else $error("no return to system power");
  a_halt_resets: assert property ($rose(digital_halt) |-> ##[0:2] chip_reset)
    else $error("halt without chip reset");
  a_chip_holds_cpu: assert property (chip_reset |-> !cpu_reset_n)
    else $error("cpu running in chip reset");
  a_debug_cpu: assert property ((clk_en && !debug_reset_n) [*4] |-> !cpu_reset_n)
    else $error("debug reset ignored");
  a_status_read: assert property (clk_en && sfr_rd && sfr_addr == 8'hf9 |=> sfr_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  a_sfr_idle: assert property (clk_en && !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_start_boot: assert property (cpu_start |-> boot_addr == 16'h0000 ##1 !cpu_start)
    else $error("bad start pulse");
  a_done_pulse: assert property (transfer_done_irq |=> !transfer_done_irq)
    else $error("done not a pulse");
  a_irq_pulse: assert property (supply_irq |=> !supply_irq)
    else $error("supply irq not a pulse");
  // ==========================================
  // Covers
  c_start: cover property (cpu_start);
  c_irq: cover property (supply_irq);
  c_done: cover property (transfer_done_irq);
  c_inhibit: cover property (flash_write_inhibit && flash_write_req);
endmodule

bind pfrs_sequencer pfrs_props pfrs_props_inst (.clk, .reset_n, .clk_en, .sfr_addr, .sfr_rd, .sfr_rdata,
  .flash_write_req, .flash_write_grant, .flash_write_inhibit, .battery_select, .amp_bias_enable,
  .converter_clock_enable, .supply_irq, .transfer_done_irq, .digital_halt, .chip_reset, .cpu_reset_n,
  .debug_reset_n, .cpu_start, .boot_addr);

// >>> tb/pfrs_far_model.sv
// Far-side model: the two 32 kHz clocks
`timescale 1ns/1ps
module pfrs_far_model #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  output logic      crystal_clock_32k,
  output logic      engine_clock_32k
);
  // ==========================================
  // Oscillators
  // Shortened period keeps the run short; both run free through any reset
  int   cnt  = 0;
  logic xtal = 1'b0;
  logic eng  = 1'b0;
  always @(posedge clk)
  begin
    cnt <= (cnt + 1) % HALF;
    if (cnt == HALF - 1) xtal <= !xtal;
    if (cnt == 1) eng <= !eng;
  end
  assign crystal_clock_32k = xtal;
  assign engine_clock_32k  = eng;
  // No watchdog in this block, so nothing to restart
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the supply and reset sequencer
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // Signals
  logic clk, reset_n, clk_en, upper_supply_ok, lower_supply_ok, core_above_225, core_above_200;
  logic reset_pin, test_pin, debug_reset_n, sfr_rd, sfr_wr, io_rd, io_wr, flash_write_req;
  logic sample_strobe, pulse_y_irq, crystal_clock_32k, engine_clock_32k;
  logic [7:0] sfr_addr, sfr_wdata, io_wdata, sfr_rdata, io_rdata;
  logic [15:0] io_addr, accumulation_sample_count, boot_addr;
  logic supply_irq, transfer_done_irq, engine_busy_irq, test_mux_output, battery_select, wake;
  logic converter_clock_enable, amp_bias_enable, flash_write_inhibit, digital_halt;
  logic chip_reset, cpu_reset_n, cpu_start, flash_write_grant;
  int error_cnt = 0;
  int cmp_count = 0;
  int irq_n = 0;
  int done_n = 0;
  int mux_n = 0;
  int n;

  pfrs_sequencer #(.PIN_TIMER_CYCLES(20), .SW_TIMER_CYCLES(4)) pfrs_sequencer_inst (.clk, .reset_n, .clk_en,
    .upper_supply_ok, .lower_supply_ok, .core_above_225, .core_above_200, .crystal_clock_32k,
    .engine_clock_32k, .reset_pin, .test_pin, .debug_reset_n, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .flash_write_req, .flash_write_grant,
    .sample_strobe, .accumulation_sample_count, .pulse_y_irq, .supply_irq, .transfer_done_irq,
    .engine_busy_irq, .test_mux_output, .battery_select, .converter_clock_enable, .amp_bias_enable,
    .flash_write_inhibit, .digital_halt, .chip_reset, .cpu_reset_n, .cpu_start, .boot_addr, .wake);
  pfrs_far_model pfrs_far_model_inst (.clk, .crystal_clock_32k, .engine_clock_32k);

  always #50 clk = !clk;
  always @(posedge clk)
  begin
    irq_n <= irq_n + int'(supply_irq === 1'b1);
    done_n <= done_n + int'(transfer_done_irq === 1'b1);
    mux_n <= mux_n + int'(test_mux_output === 1'b1);
  end

  // ==========================================
  // Helpers
  task test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cy(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  // Bounded wait: 0 start pulse, 1 chip reset, 2 wake low
  task wt(input int s, input int lim, output int c);
    c = 0;
    while ((s == 0 ? cpu_start : s == 1 ? chip_reset : !wake) !== 1'b1 && c < lim)
    begin
      cy(1);
      c++;
    end
    if (c >= lim)
    begin
      error_cnt++;
      $display("Error %0t: wait ran out", $time);
      test_done;
    end
  endtask
  task sr(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cy(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  task ir(input logic [15:0] a, output logic [7:0] d);
    io_addr = a;
    io_rd = 1'b1;
    cy(1);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  task iw(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cy(1);
    io_wr = 1'b0;
  endtask
  task set_sup(input logic [3:0] v);
    {upper_supply_ok, lower_supply_ok, core_above_225, core_above_200} = v;
  endtask

  // ==========================================
  // Scenarios
  task t_walk;
    logic [7:0] d;
    int i0;
    iw(16'h2704, 8'h10);
    ir(16'h2704, d);
    ck(d, 8'h10);
    cy(2);
    for (int k = 1; k < 4; k++)
    begin
      i0 = irq_n;
      set_sup(4'hf >> k);
      cy(8);
      ck(irq_n - i0, 1);
      sr(8'hf9, d);
      ck(d, k);
      ck(battery_select, k > 1);
      ck(amp_bias_enable, k < 2);
      ck(converter_clock_enable, k < 2);
      flash_write_req = 1'b1;
      #1 ck(flash_write_grant, k < 3);
      flash_write_req = 1'b0;
    end
    sfr_addr = 8'hf9;
    sfr_wdata = 8'h07;
    sfr_wr = 1'b1;
    cy(1);
    sfr_wr = 1'b0;
    sr(8'hf9, d);
    ck(d, 3);
    set_sup(4'hf);
    cy(8);
    ck(battery_select, 0);
    ck(converter_clock_enable, 1);
    sr(8'hf8, d);
    ck(d, 0);
  endtask
  task t_accum;
    int d0, m0;
    iw(16'h2502, 8'h18);
    d0 = done_n;
    m0 = mux_n;
    for (int k = 0; k < 3; k++)
    begin
      sample_strobe = 1'b1;
      cy(1);
      sample_strobe = 1'b0;
      cy(2);
      if (k == 0) ck(engine_busy_irq, 1);
    end
    cy(4);
    ck(done_n - d0, 1);
    ck(mux_n - m0, 1);
    ck(engine_busy_irq, 0);
  endtask
  task t_debug;
    clk_en = 1'b0;
    debug_reset_n = 1'b0;
    cy(6);
    ck(cpu_reset_n, 1);
    clk_en = 1'b1;
    cy(6);
    ck(cpu_reset_n, 0);
    ck(chip_reset, 0);
    debug_reset_n = 1'b1;
    cy(5);
    ck(cpu_reset_n, 1);
  endtask
  task t_soft;
    iw(16'h2200, 8'h08);
    wt(1, 5, n);
    wt(0, 100, n);
    ck(n < 80, 1);
    iw(16'h28b2, 8'h80);
    wt(2, 5, n);
    wt(0, 300, n);
    ck(wake, 1);
  endtask
  task t_pin;
    logic [7:0] d;
    iw(16'h2704, 8'h10);
    iw(16'h2502, 8'h19);
    pulse_y_irq = 1'b1;
    cy(3);
    ck(test_mux_output, 1);
    reset_pin = 1'b1;
    cy(25);
    ck(digital_halt, 1);
    ck(chip_reset, 1);
    reset_pin = 1'b0;
    wt(0, 300, n);
    ck(n >= 144, 1);
    ck(converter_clock_enable, 0);
    ck(test_mux_output, 1);
    ir(16'h2704, d);
    ck(d, 8'h00);
    ir(16'h2502, d);
    ck(d, 8'h19);
    {test_pin, reset_pin} = 2'b11;
    cy(25);
    {test_pin, reset_pin} = 2'b00;
    wt(0, 300, n);
    ck(test_mux_output, 0);
    pulse_y_irq = 1'b0;
  endtask
  task t_collapse;
    logic [7:0] d;
    set_sup(4'h0);
    cy(5);
    sr(8'hf9, d);
    ck(d, 5);
    ck(flash_write_inhibit, 1);
    wt(1, 60, n);
    ck(n >= 16, 1);
    set_sup(4'hf);
    wt(0, 400, n);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    set_sup(4'hf);
    debug_reset_n = 1'b1;
    {reset_pin, test_pin, sfr_rd, sfr_wr, io_rd, io_wr, flash_write_req, sample_strobe, pulse_y_irq} = '0;
    {sfr_addr, sfr_wdata, io_wdata, io_addr} = '0;
    accumulation_sample_count = 16'h0003;
    cy(3);
    reset_n = 1'b1;
    wt(0, 300, n);
    ck(n >= 144, 1);
    t_walk;
    t_accum;
    t_debug;
    t_soft;
    t_pin;
    t_collapse;
    test_done;
  end
endmodule
